// >>> hw/i2c_channel_switch.sv
// channel switch control logic: two-wire slave, control register, irq
// Operation
// - master addresses switch after start
// - address last bit: 1 read, 0 write
// - one written data byte loads control register
// - several written bytes keep only last
// - control register writable and readable
// - low four bits enable matching channels
// - new selection applied only at stop
// - power-on reset clears register and state
// - low reset pin clears and deselects
// - any low irq input drives output low
// - irq detection ignores channel enables
// - bits four to seven show irq status
// - irq inputs sampled when read happens
// - status bit one means input asserted
// - master polls all devices on channel
// - irq inputs usable as general inputs
// - irq output valid within 4 us
// - irq output released within 2 us
// - master waits bus free time
// - sda held 300 ns after scl fall
// - ack driven within 1 us
`timescale 1ns/1ps
module i2c_channel_switch
    import i2c_switch_pkg::*;
#(
    parameter logic [4:0] ADDR_UPPER = ADDR_FIXED
) (
    i2c_switch_if.slave          bus,
    input  wire logic            mclk,
    input  wire logic            rst,
    input  wire logic            ce,
    input  wire logic            resetPinN,
    input  wire logic            addrPinLo,
    input  wire logic            addrPinHi,
    input  wire logic [3:0]      irqInChN,
    output logic [3:0]           chanSel,
    output logic                 irqAnyOut,
    output logic                 irqAnyOe
);

    localparam int PINS = 9;

    logic [PINS-1:0] pinMeta;
    logic [PINS-1:0] pinSync;
    logic            sclPrev;
    logic            sdaPrev;
    slave_state_t    state;
    logic [2:0]      bitCnt;
    logic [7:0]      shiftReg;
    logic [7:0]      txShift;
    logic            rw;
    logic            ackArm;
    logic [3:0]      pendSel;
    logic            pendValid;
    logic            pendOe;
    logic [2:0]      holdCnt;
    logic            sdaOe;

    wire logic [PINS-1:0] pinRaw = {bus.scl, bus.sda, resetPinN, addrPinHi,
                                    addrPinLo, irqInChN};
    wire logic       sclS    = pinSync[8];
    wire logic       sdaS    = pinSync[7];
    wire logic       rstPinS = pinSync[6];
    wire logic       addrHiS = pinSync[5];
    wire logic       addrLoS = pinSync[4];
    wire logic [3:0] irqS    = pinSync[3:0];

    // bus events from the synchronised lines
    wire logic sclRise   = sclS & ~sclPrev;
    wire logic sclFall   = ~sclS & sclPrev;
    wire logic startCond = sclS & sclPrev & sdaPrev & ~sdaS;
    wire logic stopCond  = sclS & sclPrev & ~sdaPrev & sdaS;
    wire logic abortBus  = ~rstPinS | startCond | stopCond;

    // byte assembly and address compare
    wire logic [7:0] rxByte  = {shiftReg[6:0], sdaS};
    wire logic       lastBit = (bitCnt == 3'd7);
    wire logic [6:0] ownAddr = {ADDR_UPPER, addrHiS, addrLoS};
    wire logic       addrHit = (rxByte[7:1] == ownAddr);

    // read byte: inverted live irq levels above the current selection
    wire logic [7:0] statusByte = {~irqS, chanSel};

    assign bus.sdaSOut = 1'b0;
    assign bus.sdaSOe  = sdaOe;

    // two-stage synchronisers for every pin, plus an edge stage on the bus
    // lines; the edge stage reads only the second flop
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pinMeta <= '1;
            pinSync <= '1;
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end else if (ce) begin
            pinMeta <= pinRaw;
            pinSync <= pinMeta;
            sclPrev <= sclS;
            sdaPrev <= sdaS;
        end
    end

    // slave bus state machine; start, stop and the reset pin abort it
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state     <= S_IDLE;
            bitCnt    <= 3'd0;
            shiftReg  <= CTRL_RESET;
            txShift   <= CTRL_RESET;
            rw        <= 1'b0;
            ackArm    <= 1'b0;
            pendSel   <= 4'h0;
            pendValid <= 1'b0;
            pendOe    <= 1'b0;
        end else if (ce) begin
            if (abortBus) begin
                // a repeated start restarts addressing
                state  <= (startCond && rstPinS) ? S_ADDR : S_IDLE;
                bitCnt <= 3'd0;
                ackArm <= 1'b0;
                pendOe <= 1'b0;
                if (!rstPinS || stopCond) begin
                    pendValid <= 1'b0;
                end
            end else begin
                unique case (state)
                    S_IDLE: begin
                        bitCnt <= 3'd0;
                    end
                    S_ADDR: begin
                        if (sclRise) begin
                            shiftReg <= rxByte;
                            bitCnt   <= bitCnt + 3'd1;
                            if (lastBit) begin
                                rw    <= sdaS;
                                state <= addrHit ? S_ACK : S_IDLE;
                            end
                        end
                    end
                    S_ACK: begin
                        // first fall: pull ack low; second fall: end of ack
                        if (sclFall && !ackArm) begin
                            pendOe <= 1'b1;
                            ackArm <= 1'b1;
                        end else if (sclFall) begin
                            ackArm <= 1'b0;
                            if (rw) begin
                                txShift <= statusByte;
                                pendOe  <= ~statusByte[7];
                                state   <= S_TX;
                            end else begin
                                pendOe <= 1'b0;
                                state  <= S_RX;
                            end
                        end
                    end
                    S_RX: begin
                        if (sclRise) begin
                            shiftReg <= rxByte;
                            bitCnt   <= bitCnt + 3'd1;
                            if (lastBit) begin
                                // later bytes overwrite earlier ones
                                pendSel   <= rxByte[3:0];
                                pendValid <= 1'b1;
                                state     <= S_ACK;
                            end
                        end
                    end
                    S_TX: begin
                        if (sclRise) begin
                            txShift <= {txShift[6:0], 1'b0};
                            bitCnt  <= bitCnt + 3'd1;
                            if (lastBit) begin
                                state <= S_MACK;
                            end
                        end else if (sclFall) begin
                            pendOe <= ~txShift[7];
                        end
                    end
                    S_MACK: begin
                        // master nack ends the read; ack resends a fresh byte
                        if (sclRise && sdaS) begin
                            state <= S_IDLE;
                        end else if (sclRise) begin
                            ackArm <= 1'b1;
                        end else if (sclFall && ackArm) begin
                            txShift <= statusByte;
                            pendOe  <= ~statusByte[7];
                            ackArm  <= 1'b0;
                            state   <= S_TX;
                        end else if (sclFall) begin
                            pendOe <= 1'b0;
                        end
                    end
                    default: begin
                        state <= S_IDLE;
                    end
                endcase
            end
        end
    end

    // sda changes only a hold time after scl fell, so the master never sees
    // data move inside the undefined part of its falling edge; the sync
    // stages add two to three cycles on top, well inside the ack limit
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            holdCnt <= 3'd0;
            sdaOe   <= 1'b0;
        end else if (ce) begin
            if (abortBus) begin
                holdCnt <= 3'd0;
                sdaOe   <= 1'b0;
            end else if (sclFall) begin
                holdCnt <= 3'(SDA_HOLD_CYC);
            end else if (holdCnt != 3'd0) begin
                holdCnt <= holdCnt - 3'd1;
                if (holdCnt == 3'd1) begin
                    sdaOe <= pendOe;
                end
            end
        end
    end

    // selection reaches the switches only at stop, when all lines are high
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            chanSel <= CTRL_RESET[3:0];
        end else if (ce) begin
            if (!rstPinS) begin
                chanSel <= CTRL_RESET[3:0];
            end else if (stopCond && pendValid) begin
                chanSel <= pendSel;
            end
        end
    end

    // open-drain irq output, independent of selection and of the bus reset;
    // three cycles of latency, far below both output limits
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irqAnyOut <= 1'b0;
            irqAnyOe  <= 1'b0;
        end else if (ce) begin
            irqAnyOut <= 1'b0;
            irqAnyOe  <= ~&irqS;
        end
    end

endmodule

// >>> hw/i2c_switch_if.sv
// upstream two-wire bus between controller and channel switch
`timescale 1ns/1ps
interface i2c_switch_if;
    logic sclOut;
    logic sclOe;
    logic sdaMOut;
    logic sdaMOe;
    logic sdaSOut;
    logic sdaSOe;
    logic scl;
    logic sda;

    // wired-and with pull-ups: a line is low while any enabled driver is low
    assign scl = ~(sclOe & ~sclOut);
    assign sda = ~((sdaMOe & ~sdaMOut) | (sdaSOe & ~sdaSOut));

    modport master (output sclOut, output sclOe, output sdaMOut,
                    output sdaMOe, input scl, input sda);
    modport slave  (output sdaSOut, output sdaSOe, input scl, input sda);
endinterface

// >>> hw/i2c_switch_master.sv
// upstream two-wire controller with a classic wishbone register slave
`timescale 1ns/1ps
module i2c_switch_master
    import i2c_switch_pkg::*;
#(
    parameter int QTR_CYC  = SCL_QTR_CYC,
    parameter int FREE_CYC = BUS_FREE_CYC
) (
    i2c_switch_if.master     bus,
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [31:0] dat_i,
    input  wire logic [3:0]  sel_i,
    output logic [31:0]      dat_o,
    output logic             ack_o
);

    master_state_t state;
    logic [15:0]   qCnt;
    logic [1:0]    phase;
    logic [3:0]    bitIdx;
    logic          byteIdx;
    logic [7:0]    shiftReg;
    logic [6:0]    slaveAddr;
    logic [7:0]    txData;
    logic [7:0]    rxData;
    logic          readMode;
    logic          busy;
    logic          nack;
    logic          sclOe;
    logic          sdaOe;
    logic          sdaMeta;
    logic          sdaS;

    // wishbone decode; ack goes high one cycle after the request
    wire logic wbReq  = cyc_i & stb_i & ~ack_o;
    wire logic wrReq  = wbReq & we_i & sel_i[0];
    wire logic goReq  = wrReq & (adr_i == REG_CMD) & dat_i[CMD_GO_BIT] & ~busy;
    wire logic [7:0] rdByte =
        (adr_i == REG_SLAVE)  ? {1'b0, slaveAddr} :
        (adr_i == REG_TXDATA) ? txData :
        (adr_i == REG_RXDATA) ? rxData :
        (adr_i == REG_STATUS) ? {6'h00, nack, busy} : 8'h00;

    // quarter-period tick, longer wait for the bus free time
    wire logic [15:0] tickEnd = (state == M_FREE) ? 16'(FREE_CYC - 1)
                                                  : 16'(QTR_CYC - 1);
    wire logic tick     = (qCnt == tickEnd);
    wire logic ackBit   = (bitIdx == 4'd8);
    wire logic sendBit  = ~byteIdx | ~readMode;
    wire logic lastByte = byteIdx | nack;

    assign bus.sclOut  = 1'b0;
    assign bus.sclOe   = sclOe;
    assign bus.sdaMOut = 1'b0;
    assign bus.sdaMOe  = sdaOe;

    // register slave; a go while busy is ignored
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ack_o     <= 1'b0;
            dat_o     <= 32'h0;
            slaveAddr <= 7'h00;
            txData    <= 8'h00;
            readMode  <= 1'b0;
        end else if (ce) begin
            ack_o <= wbReq;
            dat_o <= wbReq ? {24'h0, rdByte} : 32'h0;
            if (wrReq && adr_i == REG_SLAVE) slaveAddr <= dat_i[6:0];
            if (wrReq && adr_i == REG_TXDATA) txData <= dat_i[7:0];
            if (goReq) readMode <= dat_i[CMD_READ_BIT];
        end
    end

    // sda comes back from the wire: two flops before use
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sdaMeta <= 1'b1;
            sdaS    <= 1'b1;
        end else if (ce) begin
            sdaMeta <= bus.sda;
            sdaS    <= sdaMeta;
        end
    end

    // bit engine: phase 0 sets sda, 1 raises scl, 2 samples, 3 lowers scl
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state    <= M_IDLE;
            qCnt     <= 16'h0;
            phase    <= 2'd0;
            bitIdx   <= 4'd0;
            byteIdx  <= 1'b0;
            shiftReg <= 8'h00;
            rxData   <= 8'h00;
            busy     <= 1'b0;
            nack     <= 1'b0;
            sclOe    <= 1'b0;
            sdaOe    <= 1'b0;
        end else if (ce) begin
            qCnt <= (state == M_IDLE || tick) ? 16'h0 : qCnt + 16'h1;
            unique case (state)
                M_IDLE: begin
                    if (goReq) begin
                        busy     <= 1'b1;
                        nack     <= 1'b0;
                        sdaOe    <= 1'b1;
                        shiftReg <= {slaveAddr, dat_i[CMD_READ_BIT]};
                        state    <= M_START;
                    end
                end
                M_START: begin
                    if (tick) begin
                        sclOe   <= 1'b1;
                        phase   <= 2'd0;
                        bitIdx  <= 4'd0;
                        byteIdx <= 1'b0;
                        state   <= M_BIT;
                    end
                end
                M_BIT: begin
                    if (tick) begin
                        phase <= phase + 2'd1;
                        unique case (phase)
                            2'd0: sdaOe <= ~ackBit & sendBit & ~shiftReg[7];
                            2'd1: sclOe <= 1'b0;
                            2'd2: begin
                                if (!ackBit) begin
                                    shiftReg <= {shiftReg[6:0], sdaS};
                                end else if (sendBit && sdaS) begin
                                    nack <= 1'b1;
                                end
                            end
                            2'd3: begin
                                sclOe <= 1'b1;
                                if (ackBit && lastByte) begin
                                    if (byteIdx && readMode) rxData <= shiftReg;
                                    phase <= 2'd0;
                                    state <= M_STOP;
                                end else if (ackBit) begin
                                    byteIdx  <= 1'b1;
                                    bitIdx   <= 4'd0;
                                    shiftReg <= txData;
                                end else begin
                                    bitIdx <= bitIdx + 4'd1;
                                end
                            end
                        endcase
                    end
                end
                M_STOP: begin
                    if (tick) begin
                        phase <= phase + 2'd1;
                        if (phase == 2'd0) sdaOe <= 1'b1;
                        if (phase == 2'd1) sclOe <= 1'b0;
                        if (phase == 2'd2) begin
                            sdaOe <= 1'b0;
                            state <= M_FREE;
                        end
                    end
                end
                M_FREE: begin
                    // stay busy for the bus free time after stop
                    if (tick) begin
                        busy  <= 1'b0;
                        state <= M_IDLE;
                    end
                end
                default: begin
                    state <= M_IDLE;
                end
            endcase
        end
    end

endmodule

// >>> hw/i2c_switch_pkg.sv
// shared constants, register map and state types for the channel switch
package i2c_switch_pkg;

    // clock and bus timing
    localparam int MCLK_NS         = 50;
    localparam int SDA_HOLD_NS     = 300;
    localparam int SDA_HOLD_CYC    = (SDA_HOLD_NS + MCLK_NS - 1) / MCLK_NS;
    localparam int ACK_VALID_NS    = 1000;
    localparam int ACK_VALID_CYC   = ACK_VALID_NS / MCLK_NS;
    localparam int IRQ_VALID_NS    = 4000;
    localparam int IRQ_VALID_CYC   = IRQ_VALID_NS / MCLK_NS;
    localparam int IRQ_RELEASE_NS  = 2000;
    localparam int IRQ_RELEASE_CYC = IRQ_RELEASE_NS / MCLK_NS;
    localparam int BUS_FREE_NS     = 4700;
    localparam int BUS_FREE_CYC    = (BUS_FREE_NS + MCLK_NS - 1) / MCLK_NS;
    localparam int SCL_PERIOD_NS   = 10000;
    localparam int SCL_QTR_CYC     = SCL_PERIOD_NS / (4 * MCLK_NS);

    // device side
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [4:0] ADDR_FIXED = 5'h10;
    localparam int         CHANNELS   = 4;

    // controller register map (byte addresses)
    localparam logic [7:0] REG_CMD    = 8'h00;
    localparam logic [7:0] REG_SLAVE  = 8'h04;
    localparam logic [7:0] REG_TXDATA = 8'h08;
    localparam logic [7:0] REG_RXDATA = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam int CMD_GO_BIT    = 0;
    localparam int CMD_READ_BIT  = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_NACK_BIT = 1;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_ADDR = 3'b001,
        S_ACK  = 3'b010,
        S_RX   = 3'b011,
        S_TX   = 3'b100,
        S_MACK = 3'b101
    } slave_state_t;

    typedef enum logic [2:0] {
        M_IDLE  = 3'b000,
        M_START = 3'b001,
        M_BIT   = 3'b010,
        M_STOP  = 3'b011,
        M_FREE  = 3'b100
    } master_state_t;

endpackage

// >>> tb/i2c_switch_monitor.sv
// concurrent checks on the upstream bus, channel enables and irq pin
`timescale 1ns/1ps
module i2c_switch_monitor (
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic       scl,
    input wire logic       sda,
    input wire logic       sdaSOut,
    input wire logic       sdaSOe,
    input wire logic       resetPinN,
    input wire logic [3:0] irqInChN,
    input wire logic [3:0] chanSel,
    input wire logic       irqAnyOe
);
    logic [5:0] lowCnt;
    logic [5:0] freeCnt;
    wire        devPull = sdaSOe & ~sdaSOut;

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    // cycles since scl fell; saturates so a long pause cannot wrap
    always_ff @(posedge mclk or posedge rst) begin
        if (rst)
            lowCnt <= 6'h00;
        else if (scl)
            lowCnt <= 6'h00;
        else if (lowCnt != 6'h3f)
            lowCnt <= lowCnt + 6'h01;
    end

    // cycles with both lines high; starts saturated so that the first
    // start after reset counts as following a free bus
    always_ff @(posedge mclk or posedge rst) begin
        if (rst)
            freeCnt <= 6'h3f;
        else if (!(scl && sda))
            freeCnt <= 6'h00;
        else if (freeCnt != 6'h3f)
            freeCnt <= freeCnt + 6'h01;
    end

    bus_free_a: assert property (
        scl && $fell(sda) |-> freeCnt >= 6'd26)
        else $error("start too soon after stop");
    irq_low_a: assert property (
        (!(&irqInChN))[*5] |-> irqAnyOe) else $error("irq pin late");
    irq_high_a: assert property (
        (&irqInChN)[*5] |-> !irqAnyOe) else $error("irq pin stuck");
    irq_cause_a: assert property (
        $rose(irqAnyOe) |-> !(&$past(irqInChN, 3)))
        else $error("irq pin without cause");
    sel_at_stop_a: assert property (
        $changed(chanSel) && resetPinN |-> scl && sda)
        else $error("selection applied before stop");
    reset_clear_a: assert property (
        (!resetPinN)[*4] |-> chanSel == 4'h0) else $error("chan not cleared");
    reset_sda_a: assert property (
        (!resetPinN)[*4] |-> !sdaSOe) else $error("sda held in reset");
    hold_time_a: assert property (
        $fell(scl) |-> ##1 $stable(sdaSOe)[*6])
        else $error("sda hold too short");
    ack_valid_a: assert property (
        $rose(devPull) |-> !scl && lowCnt <= 6'h14 && lowCnt >= 6'h06)
        else $error("sda low drive out of window");
    still_high_a: assert property (
        scl && $past(scl) |-> $stable(sdaSOe))
        else $error("sda moved while scl high");
endmodule

// >>> tb/testbench.sv
// self-checking bench: wishbone-driven controller facing the switch
`timescale 1ns/1ps
module testbench
    import i2c_switch_pkg::*;
;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] datI = 32'h0;
    logic [31:0] datO;
    logic        ack;
    logic        resetPinN = 1'b1;
    logic [1:0]  pins = 2'h0;
    logic [3:0]  irqN = 4'hf;
    logic [3:0]  chanSel;
    logic        irqAnyOe;
    logic        irqAnyOut;
    wire logic   irqPin = irqAnyOe ? irqAnyOut : 1'b1;
    logic        nk;
    logic [7:0]  rx;
    logic [7:0]  d;
    logic [3:0]  lvl;
    logic [31:0] q;
    int          seed = 32'ha88fa526;
    int          n_mismatch = 0;
    int          cmp_count = 0;

    // free-running 20 MHz clock
    always #25 mclk = ~mclk;

    i2c_switch_if link ();
    // fast-mode bus: 385 kHz clock, 1.3 us low time and bus free time
    i2c_switch_master #(.QTR_CYC(13), .FREE_CYC(26)) i_i2c_switch_master (
        .bus(link), .mclk, .rst, .ce(1'b1), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .dat_i(datI), .sel_i(4'h1), .dat_o(datO),
        .ack_o(ack));
    i2c_channel_switch i_i2c_channel_switch (.bus(link), .mclk, .rst,
        .ce(1'b1), .resetPinN, .addrPinLo(pins[0]), .addrPinHi(pins[1]),
        .irqInChN(irqN), .chanSel, .irqAnyOut, .irqAnyOe);
    i2c_switch_monitor i_i2c_switch_monitor (.mclk, .rst, .scl(link.scl),
        .sda(link.sda), .sdaSOut(link.sdaSOut), .sdaSOe(link.sdaSOe),
        .resetPinN, .irqInChN(irqN), .chanSel, .irqAnyOe);

    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // read byte: irq status above the selection, set bit = asserted input
    function automatic logic [7:0] expByte(input logic [3:0] irqLvl,
                                           input logic [7:0] wr);
        return {~irqLvl, wr[3:0]};
    endfunction

    // irq pin level with its pull-up: low while any input is low
    function automatic logic expPin(input logic [3:0] irqLvl);
        return &irqLvl;
    endfunction

    // a wait that ran out is a failure in itself
    task automatic giveUp;
        n_mismatch++;
        test_done;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // one classic cycle; request held until the edge that sees ack
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] v);
        int k;
        k = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        datI <= v;
        do begin
            @(posedge mclk);
            k++;
        end while (ack !== 1'b1 && k < 50);
        if (ack !== 1'b1)
            giveUp;
        q = datO;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge mclk);
    endtask

    // one switch transaction, polled until the controller is idle
    task automatic xfer(input logic [6:0] a, input logic rd,
                        input logic [7:0] v);
        int k;
        k = 0;
        wb(1'b1, REG_SLAVE, {25'h0, a});
        wb(1'b1, REG_TXDATA, {24'h0, v});
        wb(1'b1, REG_CMD, {30'h0, rd, 1'b1});
        do begin
            wb(1'b0, REG_STATUS, 32'h0);
            k++;
        end while (q[STAT_BUSY_BIT] !== 1'b0 && k < 1000);
        if (q[STAT_BUSY_BIT] !== 1'b0)
            giveUp;
        nk = q[STAT_NACK_BIT];
        wb(1'b0, REG_RXDATA, 32'h0);
        rx = q[7:0];
    endtask

    // main sequence: reset, addressing, status reads, reset pin
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        chk8({4'h0, chanSel}, 8'h00);
        wb(1'b1, 8'h14, 32'hff);
        wb(1'b0, 8'h14, 32'h0);
        chk8(q[7:0], 8'h00);
        wb(1'b1, REG_TXDATA, 32'h5a);
        wb(1'b0, REG_TXDATA, 32'h0);
        chk8(q[7:0], 8'h5a);
        wb(1'b1, REG_SLAVE, 32'hff);
        wb(1'b0, REG_SLAVE, 32'h0);
        chk8(q[7:0], 8'h7f);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            pins <= i[1:0];
            repeat (4) @(posedge mclk);
            d = 8'($random(seed));
            xfer({ADDR_FIXED, i[1:0]}, 1'b0, d);
            chk1(nk, 1'b0);
            chk8({4'h0, chanSel}, {4'h0, d[3:0]});
            xfer({ADDR_FIXED, ~i[1:0]}, 1'b0, ~d);
            chk1(nk, 1'b1);
            chk8({4'h0, chanSel}, {4'h0, d[3:0]});
        end
        $display("test address done");
        for (int i = 0; i < 6; i++) begin
            d = 8'($random(seed));
            lvl = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : 4'($random(seed));
            irqN <= lvl;
            xfer({ADDR_FIXED, pins}, 1'b0, d);
            xfer({ADDR_FIXED, pins}, 1'b1, 8'h00);
            chk8(rx, expByte(lvl, d));
            chk1(irqAnyOe, ~expPin(lvl));
            chk1(irqPin, expPin(lvl));
        end
        $display("test status done");
        xfer({ADDR_FIXED, pins}, 1'b0, 8'h0f);
        resetPinN <= 1'b0;
        repeat (6) @(posedge mclk);
        chk8({4'h0, chanSel}, 8'h00);
        resetPinN <= 1'b1;
        repeat (4) @(posedge mclk);
        xfer({ADDR_FIXED, pins}, 1'b1, 8'h00);
        chk8(rx, expByte(lvl, 8'h00));
        $display("test reset pin done");
        test_done;
    end
endmodule
